// [verilog/jtag_tap.sv]
// boundary-scan test access port with two-bit instruction register
// Contract
// R1: TMS sampled on test clock rise
// R2: undriven TMS reads as one
// R3: TDI sampled on test clock rise
// R4: undriven TDI reads as one
// R5: TDI routed to IR or data register
// R6: TDO changes on test clock fall
// R7: TDO driver off unless shifting
// R8: test clock independent of functional clocks; the logic here samples it and registers everything on mclk
// R9: scan cell between core and pin
// R10: two-bit IR loaded in Shift-IR
// R11: instruction selects data register path
// R12: code 00 extest, pins from scan
// R13: code 01 sample/preload, core untouched
// R14: code 10 bypass, pins from scan
// R15: code 11 bypass, normal operation
// R16: reset loads bypass-no-test instruction
// R17: bypass register is one stage
// R18: 84 cells, cell 0 out first
// R19: enable cells active high
// R20: standard sixteen-state controller
// R21: Capture-IR loads pattern 01
`timescale 1ns/1ps
module jtag_tap
   import tap_pkg::*;
#(
   parameter int CELLS = BSR_LEN
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             tck,
   input  wire logic             tms,
   input  wire logic             tdi,
   input  wire logic             tmsDriven,
   input  wire logic             tdiDriven,
   input  wire logic [CELLS-1:0] pinIn,
   input  wire logic [CELLS-1:0] coreOut,
   output logic                  tdoOut,
   output logic                  tdoOe,
   output logic      [CELLS-1:0] pinOut,
   output logic                  testMode,
   output logic      [1:0]       instr
);

   // the shift chain needs a head cell and at least one body cell
   if (CELLS < 2) begin : g_bad_cells
      $error("jtag_tap: CELLS must be at least 2");
   end
   // the instruction path is wired for exactly two bits
   if (IR_LEN != 2) begin : g_bad_ir
      $error("jtag_tap: IR_LEN must be 2");
   end

   // all state in one record, registered in one place
   typedef struct packed {
      logic             tckPrev;
      tap_state_t       state;
      logic [1:0]       irShift;
      logic [1:0]       ir;
      logic             bypass;
      logic [CELLS-1:0] bsrShift;
      logic [CELLS-1:0] bsrLatch;
      logic             tdo;
      logic             tdoOe;
      logic [CELLS-1:0] pinOut;
      logic             testMode;
   } tap_regs_t;

   tap_regs_t r_q;
   tap_regs_t r_d;
   logic [4:0] pinSync;
   logic       tckS;
   logic       tmsS;
   logic       tdiS;
   logic       rise;
   logic       fall;
   logic       tmsDrvS;
   logic       tdiDrvS;
   logic       bsrSel;
   logic       testNext;
   logic       shiftBit;

   logic [CELLS-1:0] cellCap;
   logic [CELLS-1:0] cellShift;
   logic [CELLS-1:0] cellLoad;
   logic [CELLS-1:0] cellDrive;

   // pins cross into mclk domain; test clock is just another input
   tap_sync #(.WIDTH(5)) u_sync (
      .mclk    (mclk),
      .resetn  (resetn),
      .asyncIn ({tck, tms, tdi, tmsDriven, tdiDriven}),
      .syncOut (pinSync)
   );

   // floating pins look like logic 1
   assign tckS    = pinSync[4];
   assign tmsDrvS = pinSync[1];
   assign tdiDrvS = pinSync[0];
   assign tmsS    = pinSync[3] | ~tmsDrvS; // R2
   assign tdiS    = pinSync[2] | ~tdiDrvS; // R4
   assign rise = tckS & ~r_q.tckPrev;
   assign fall = ~tckS & r_q.tckPrev;

   function automatic tap_state_t nextState(input tap_state_t s,
                                            input logic m);
      unique case (s)
         // reset and idle
         TLR: begin
            nextState = m ? TLR : RTI;
         end
         RTI: begin
            nextState = m ? SEL_DR : RTI;
         end

         // data register column
         SEL_DR: begin
            nextState = m ? SEL_IR : CAP_DR;
         end
         CAP_DR: begin
            nextState = m ? EXIT1_DR : SHIFT_DR;
         end
         SHIFT_DR: begin
            nextState = m ? EXIT1_DR : SHIFT_DR;
         end
         EXIT1_DR: begin
            nextState = m ? UPD_DR : PAUSE_DR;
         end
         PAUSE_DR: begin
            nextState = m ? EXIT2_DR : PAUSE_DR;
         end
         EXIT2_DR: begin
            nextState = m ? UPD_DR : SHIFT_DR;
         end
         UPD_DR: begin
            nextState = m ? SEL_DR : RTI;
         end

         // instruction register column
         SEL_IR: begin
            nextState = m ? TLR : CAP_IR;
         end
         CAP_IR: begin
            nextState = m ? EXIT1_IR : SHIFT_IR;
         end
         SHIFT_IR: begin
            nextState = m ? EXIT1_IR : SHIFT_IR;
         end
         EXIT1_IR: begin
            nextState = m ? UPD_IR : PAUSE_IR;
         end
         PAUSE_IR: begin
            nextState = m ? EXIT2_IR : PAUSE_IR;
         end
         EXIT2_IR: begin
            nextState = m ? UPD_IR : SHIFT_IR;
         end
         UPD_IR: begin
            nextState = m ? SEL_DR : RTI;
         end
      endcase
   endfunction : nextState

   // true for instructions that hand the pins to the scan latches
   function automatic logic isTest(input logic [1:0] code);
      isTest = (code == INS_EXTEST) || (code == INS_BYP_TEST);
   endfunction : isTest

   function automatic logic bsrSelected(input logic [1:0] code);
      bsrSelected = (code == INS_EXTEST) || (code == INS_SAMPLE);
   endfunction : bsrSelected

   // serial output bit for whichever path is being shifted
   function automatic logic tdoBit(input tap_regs_t r);
      if (r.state == SHIFT_IR) tdoBit = r.irShift[0];
      else if (bsrSelected(r.ir)) tdoBit = r.bsrShift[0];
      else tdoBit = r.bypass;
   endfunction : tdoBit

   // instruction decode shared by the cells and the output mux
   assign bsrSel   = bsrSelected(r_q.ir); // R11
   assign testNext = isTest(r_q.ir); // R12 R14 R15
   assign shiftBit = tdoBit(r_q); // R6

   // one boundary cell per pin: observe, shift, update and control
   for (genvar i = 0; i < CELLS; i++) begin : g_cell
      if (i == CELLS - 1) begin : g_head
         // the cell farthest from the output takes the serial bit
         assign cellShift[i] = tdiS; // R18
      end else begin : g_body
         assign cellShift[i] = r_q.bsrShift[i+1]; // R18
      end
      // observe side: the pin as it stands at capture
      assign cellCap[i]   = pinIn[i]; // R9
      // latches hold unless a boundary instruction updates them
      assign cellLoad[i]  = bsrSel ? r_q.bsrShift[i] : r_q.bsrLatch[i];
      // control side: scan latch or core value towards the pin
      assign cellDrive[i] = testNext ? r_q.bsrLatch[i] : coreOut[i]; // R9
   end : g_cell

   always_comb begin
      r_d = r_q;
      r_d.tckPrev = tckS;
      if (rise) begin
         r_d.state = nextState(r_q.state, tmsS); // R1 R20
         unique case (r_q.state)
            TLR: begin
               r_d.ir = IR_RESET_VAL;
            end
            CAP_IR: begin
               r_d.irShift = IR_CAPTURE_VAL; // R21
            end
            SHIFT_IR: begin
               r_d.irShift = {tdiS, r_q.irShift[1]}; // R3 R5 R10
            end
            UPD_IR: begin
               r_d.ir = r_q.irShift;
            end
            CAP_DR: begin
               if (bsrSelected(r_q.ir)) begin
                  r_d.bsrShift = cellCap; // R9 R13
               end else begin
                  // bypass captures a fixed zero
                  r_d.bypass = 1'b0; // R17
               end
            end
            SHIFT_DR: begin
               if (bsrSelected(r_q.ir)) begin
                  // cell 0 leaves first on the output
                  r_d.bsrShift = cellShift; // R18
               end else begin
                  r_d.bypass = tdiS; // R11 R17
               end
            end
            UPD_DR: begin
               if (bsrSelected(r_q.ir)) begin
                  r_d.bsrLatch = cellLoad; // R13
               end
            end
            RTI, SEL_DR, SEL_IR,
            EXIT1_DR, PAUSE_DR, EXIT2_DR,
            EXIT1_IR, PAUSE_IR, EXIT2_IR: begin
               // no register moves in these states
            end
         endcase
      end
      if (fall) begin
         // output moves on the falling edge so the tester samples it stably
         unique case (r_q.state)
            SHIFT_IR: begin
               r_d.tdo   = r_q.irShift[0]; // R6
               r_d.tdoOe = 1'b1;
            end
            SHIFT_DR: begin
               r_d.tdo   = shiftBit; // R6 R11
               r_d.tdoOe = 1'b1;
            end
            TLR, RTI, SEL_DR, CAP_DR,
            EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
            SEL_IR, CAP_IR,
            EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR: begin
               r_d.tdo   = 1'b0;
               r_d.tdoOe = 1'b0; // R7
            end
         endcase
      end
      // test mode is a plain active-high decode of the instruction, not a bit of the latch
      r_d.testMode = testNext; // R12 R14 R15 R19
      r_d.pinOut   = cellDrive; // R9 R12
   end

   // the whole test path runs off sampled pins, registered on the core clock mclk rather than on the test clock
   always_ff @(posedge mclk or negedge resetn) begin // R8
      if (!resetn) begin
         // test clock idles high, so no false edge follows reset
         r_q.tckPrev  <= 1'b1;
         r_q.state    <= TLR; // R20
         r_q.irShift  <= IR_RESET_VAL;
         r_q.ir       <= IR_RESET_VAL; // R16
         r_q.bypass   <= 1'b0;
         r_q.bsrShift <= '0;
         r_q.bsrLatch <= '0;
         r_q.tdo      <= 1'b0;
         r_q.tdoOe    <= 1'b0;
         r_q.pinOut   <= '0;
         r_q.testMode <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign tdoOut   = r_q.tdo;
   assign tdoOe    = r_q.tdoOe;
   assign pinOut   = r_q.pinOut;
   assign testMode = r_q.testMode;
   assign instr    = r_q.ir;

endmodule : jtag_tap

// [include/tap_pkg.sv]
// shared constants and types for the boundary-scan test access port
package tap_pkg;

   localparam int BSR_LEN = 84;
   localparam int IR_LEN  = 2;

   // instruction codes
   localparam logic [1:0] INS_EXTEST    = 2'h0;
   localparam logic [1:0] INS_SAMPLE    = 2'h1;
   localparam logic [1:0] INS_BYP_TEST  = 2'h2;
   localparam logic [1:0] INS_BYP_NOTST = 2'h3;

   localparam logic [1:0] IR_RESET_VAL   = INS_BYP_NOTST;
   localparam logic [1:0] IR_CAPTURE_VAL = 2'h1;

   // sixteen-state controller, gray codes in listing order
   typedef enum logic [3:0] {
      TLR       = 4'h0,
      RTI       = 4'h1,
      SEL_DR    = 4'h3,
      CAP_DR    = 4'h2,
      SHIFT_DR  = 4'h6,
      EXIT1_DR  = 4'h7,
      PAUSE_DR  = 4'h5,
      EXIT2_DR  = 4'h4,
      UPD_DR    = 4'hC,
      SEL_IR    = 4'hD,
      CAP_IR    = 4'hF,
      SHIFT_IR  = 4'hE,
      EXIT1_IR  = 4'hA,
      PAUSE_IR  = 4'hB,
      EXIT2_IR  = 4'h9,
      UPD_IR    = 4'h8
   } tap_state_t;

endpackage : tap_pkg

// [verilog/tap_sync.sv]
// two-flop synchroniser for the test pins, sampled on the core clock
`timescale 1ns/1ps
module tap_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   if (WIDTH < 1) begin : g_bad_width
      $error("tap_sync: WIDTH must be at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] held;
   } sync_regs_t;

   sync_regs_t r_q;
   sync_regs_t r_d;

   always_comb begin
      r_d      = r_q;
      r_d.meta = asyncIn;
      // only the second stage leaves; the first may still be settling
      r_d.held = r_q.meta;
   end

   // reset to ones: undriven test pins read as 1
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r_q <= '1;
      end else begin
         r_q <= r_d;
      end
   end

   assign syncOut = r_q.held;
endmodule : tap_sync

// [verif/jtag_tap_chk.sv]
// assertion checker for the test access port ports
`timescale 1ns/1ps
module jtag_tap_chk
   import tap_pkg::*;
#(
   parameter int CELLS = BSR_LEN
) (
   input wire logic             mclk,
   input wire logic             resetn,
   input wire logic             tck,
   input wire logic             tdoOut,
   input wire logic             tdoOe,
   input wire logic [CELLS-1:0] pinOut,
   input wire logic [CELLS-1:0] coreOut,
   input wire logic             testMode,
   input wire logic [1:0]       instr
);
   // raw test clock history; the window spans the synchroniser delay
   logic [5:0] hist_q;
   logic       fellWin;
   logic       roseWin;
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn) hist_q <= '1;
      else hist_q <= {hist_q[4:0], tck};
   assign fellWin = |(hist_q[5:1] & ~hist_q[4:0]);
   assign roseWin = |(~hist_q[5:1] & hist_q[4:0]);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence s_release;
      $rose(resetn);
   endsequence
   a_tdo_on_fall: assert property ($changed(tdoOut) |-> fellWin)
      else $error("serial out moved away from a clock fall");
   a_oe_on_fall: assert property ($changed(tdoOe) |-> fellWin)
      else $error("out enable moved away from a clock fall");
   a_instr_on_rise: assert property ($changed(instr) |-> roseWin)
      else $error("instruction moved away from a clock rise");
   a_instr_held_shift: assert property (tdoOe |=> $stable(instr))
      else $error("instruction moved during a shift");
   a_mode_decode: assert property (testMode == !$past(instr[0]))
      else $error("test mode does not match instruction");
   a_reset_ir: assert property (s_release |-> instr == IR_RESET_VAL)
      else $error("instruction wrong after reset");
   a_core_pins: assert property ($past(resetn)
      && !testMode && !$past(testMode)
      |-> pinOut == $past(coreOut))
      else $error("pins do not follow core");
   a_test_pins: assert property (testMode && $past(testMode)
      && $changed(pinOut) |-> roseWin)
      else $error("test pins moved away from a clock rise");
endmodule : jtag_tap_chk
bind jtag_tap jtag_tap_chk #(.CELLS(CELLS)) chk_inst (.mclk, .resetn,
   .tck, .tdoOut, .tdoOe, .pinOut, .coreOut, .testMode, .instr);

// [verif/scan_tester.sv]
// behavioural boundary-scan tester driving the test pins
`timescale 1ns/1ps
module scan_tester (
   input  wire logic mclk,
   input  wire logic tdoOut,
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   initial begin
      // idle high between frames, as the design expects after reset
      tck = 1'h1;
      tms = 1'h1;
      tdi = 1'h1;
   end
   // one 48 ns test clock period; data moves only at the fall
   task automatic step(input logic m, input logic d, output logic o);
      @(posedge mclk);
      tck <= 1'h0;
      tms <= m;
      tdi <= d;
      repeat (6) @(posedge mclk);
      o = tdoOut;
      tck <= 1'h1;
      repeat (5) @(posedge mclk);
   endtask : step
endmodule : scan_tester

// [verif/jtag_tap_tb.sv]
// self-checking bench for the test access port
`timescale 1ns/1ps
module jtag_tap_tb;
   import tap_pkg::*;
   logic               mclk, resetn, tck, tms, tdi, tmsDriven, tdiDriven;
   logic               tdoOut, tdoOe, testMode;
   logic [BSR_LEN-1:0] pinIn, coreOut, pinOut, got;
   logic [1:0]         instr;
   int                 n_fail = 0, comparisons = 0, cyc = 0;
   jtag_tap jtag_tap_inst (.mclk, .resetn, .tck, .tms, .tdi, .tmsDriven,
      .tdiDriven, .pinIn, .coreOut, .tdoOut, .tdoOe, .pinOut, .testMode,
      .instr);
   scan_tester scan_tester_inst (.mclk, .tdoOut, .tck, .tms, .tdi);
   task automatic chk(input string nm, input logic [BSR_LEN-1:0] e, s);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic st(input logic m);
      logic o;
      scan_tester_inst.step(m, 1'h0, o);
   endtask : st
   // starts and ends in run-test/idle
   task automatic load_ir(input logic [1:0] c, input logic [1:0] e);
      logic [1:0] cap;
      st(1); st(1); st(0); st(0);
      scan_tester_inst.step(0, c[0], cap[0]);
      scan_tester_inst.step(1, c[1], cap[1]);
      st(1); st(0);
      repeat (8) @(posedge mclk);
      chk("ir capture", IR_CAPTURE_VAL, cap);
      chk("instr", e, instr);
      chk("test mode", !e[0], testMode);
   endtask : load_ir
   task automatic scan_dr(input logic [BSR_LEN-1:0] din, input int n);
      st(1); st(0); st(0);
      for (int i = 0; i < n; i++)
         scan_tester_inst.step(i == n - 1, din[i], got[i]);
      st(1); st(0);
      repeat (8) @(posedge mclk);
   endtask : scan_dr
   task automatic t_reset;
      repeat (4) @(posedge mclk);
      chk("instr", IR_RESET_VAL, instr);
      chk("tdo enable", 1'h0, tdoOe);
      chk("pins", coreOut, pinOut);
      st(0);
   endtask : t_reset
   task automatic t_codes;
      for (int c = 0; c < 4; c++) load_ir(c[1:0], c[1:0]);
   endtask : t_codes
   task automatic t_bypass;
      for (int c = 2; c < 4; c++) begin
         load_ir(c[1:0], c[1:0]);
         scan_dr(84'h5, 3);
         chk("bypass path", 84'h2, got[2:0]);
      end
   endtask : t_bypass
   task automatic t_bsr;
      pinIn <= {7{12'h1A7}};
      load_ir(2'h1, 2'h1);
      scan_dr({7{12'hE53}}, BSR_LEN);
      chk("sampled cells", pinIn, got);
      chk("pins sample", coreOut, pinOut);
      load_ir(2'h0, 2'h0);
      chk("pins extest", {7{12'hE53}}, pinOut);
      load_ir(2'h3, 2'h3);
      chk("pins normal", coreOut, pinOut);
   endtask : t_bsr
   task automatic t_undriven;
      load_ir(2'h2, 2'h2);
      tdiDriven <= 1'h0;
      load_ir(2'h0, 2'h3);
      tdiDriven <= 1'h1;
      load_ir(2'h0, 2'h0);
      tmsDriven <= 1'h0;
      repeat (5) st(0);
      tmsDriven <= 1'h1;
      st(0);
      repeat (8) @(posedge mclk);
      chk("tms undriven", IR_RESET_VAL, instr);
   endtask : t_undriven
   initial begin
      resetn = 1'h0;
      tmsDriven = 1'h1;
      tdiDriven = 1'h1;
      pinIn = '0;
      coreOut = {21{4'h6}};
      repeat (8) @(posedge mclk);
      resetn <= 1'h1;
      t_reset();
      t_codes();
      t_bypass();
      t_bsr();
      t_undriven();
      close_out();
   end
endmodule : jtag_tap_tb
